// ===== design/assc_defines.svh
// constants of the converter control block: offsets, fields and counts
`ifndef ASSC_DEFINES_SVH
`define ASSC_DEFINES_SVH

// ----------------------------------------------------------------
// converter timing in converter clock cycles, the prescale ratio and the full-scale code
// ----------------------------------------------------------------
`define ASSC_PRESC_DIV 4'd4
`define ASSC_FIRST_CYCLES 5'd25
`define ASSC_NORMAL_CYCLES 5'd13
`define ASSC_SAMPLE_LEFT 5'd12
`define ASSC_FULL_SCALE 10'h3ff

// ----------------------------------------------------------------
// controller register offsets (byte addresses)
// ----------------------------------------------------------------
`define ASSC_OFS_CTRL 4'h0
`define ASSC_OFS_STAT 4'h4
`define ASSC_OFS_SLEEP 4'h8

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define ASSC_CTRL_EN 0
`define ASSC_CTRL_START 1
`define ASSC_CTRL_FREE 2
`define ASSC_CTRL_IE 3
`define ASSC_CTRL_CHAN_LO 8
`define ASSC_CTRL_CHAN_HI 12
`define ASSC_CTRL_REF_LO 14
`define ASSC_CTRL_REF_HI 15

// ----------------------------------------------------------------
// status and sleep register fields
// ----------------------------------------------------------------
`define ASSC_STAT_DONE 0
`define ASSC_STAT_BUSY 1
`define ASSC_STAT_ASLEEP 2
`define ASSC_STAT_RES_LO 16
`define ASSC_STAT_RES_HI 25
`define ASSC_SLEEP_MODE_LO 0
`define ASSC_SLEEP_MODE_HI 2

`endif

// ===== design/assc_pkg.sv
// types shared by the converter control block and its controller
package assc_pkg;

  // reference select field encoding
  typedef enum logic [1:0] {
    ASSC_REF_EXT = 2'b00,
    ASSC_REF_SUPPLY = 2'b01,
    ASSC_REF_RSVD = 2'b10,
    ASSC_REF_INT = 2'b11
  } assc_ref_e;

  // processor sleep states
  typedef enum logic [2:0] {
    ASSC_SLP_IDLE = 3'h0,
    ASSC_SLP_NOISE = 3'h1,
    ASSC_SLP_PDOWN = 3'h2,
    ASSC_SLP_PSAVE = 3'h3,
    ASSC_SLP_STBY = 3'h6,
    ASSC_SLP_XSTBY = 3'h7
  } assc_sleep_e;

  typedef enum logic [2:0] {
    ASSC_CV_IDLE = 3'b001,
    ASSC_CV_WAIT = 3'b010,
    ASSC_CV_CONV = 3'b100
  } assc_conv_e;

  typedef enum logic [2:0] {
    ASSC_CPU_RUN = 3'b001,
    ASSC_CPU_HALTING = 3'b010,
    ASSC_CPU_SLEEP = 3'b100
  } assc_cpu_e;

endpackage

// ===== design/assc_link_if.sv
// link between the processor-side controller and the converter control
interface assc_link_if;
  import assc_pkg::*;

  logic converter_enable_bit;
  logic start_wr;
  logic free_running_select_bit;
  logic [4:0] chan_sel;
  logic [1:0] reference_select_field;
  logic done_clr;
  logic cpu_halted;
  logic [2:0] sleep_mode;
  logic conversion_start_bit;
  logic conversion_done_flag;
  logic busy;
  logic [9:0] result;

  modport dev (
    input converter_enable_bit,
    input start_wr,
    input free_running_select_bit,
    input chan_sel,
    input reference_select_field,
    input done_clr,
    input cpu_halted,
    input sleep_mode,
    output conversion_start_bit,
    output conversion_done_flag,
    output busy,
    output result
  );

  modport host (
    output converter_enable_bit,
    output start_wr,
    output free_running_select_bit,
    output chan_sel,
    output reference_select_field,
    output done_clr,
    output cpu_halted,
    output sleep_mode,
    input conversion_start_bit,
    input conversion_done_flag,
    input busy,
    input result
  );
endinterface

// ===== design/assc_device.sv
// converter control: start, selection locking, saturation, sleep start
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`include "assc_defines.svh"

module assc_device
  import assc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  assc_link_if.dev link,
  input wire logic [10:0] ain_level,
  output logic [4:0] chan_o,
  output logic [1:0] ref_sel_o,
  output logic supply_sw_o,
  output logic bandgap_on_o,
  output logic sample_o,
  output logic converting_o
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // anything at or above the reference reads as full scale
  function automatic logic [9:0] sat_code(input logic [10:0] lvl);
    sat_code = lvl[10] ? `ASSC_FULL_SCALE : lvl[9:0];
  endfunction

  // supply switch and bandgap amplifier from the select field
  function automatic logic [1:0] ref_drive(input logic [1:0] sel);
    case (sel)
      ASSC_REF_SUPPLY: ref_drive = 2'b10;
      ASSC_REF_INT: ref_drive = 2'b01;
      default: ref_drive = 2'b00; // external pin; reserved kept safe
    endcase
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  assc_conv_e state_q;
  logic [3:0] presc_q;
  logic tick;
  logic [4:0] cnt_q;
  logic first_q;
  logic start_q;
  logic done_q;
  logic [9:0] result_q;
  logic [9:0] sample_q;
  logic sample_pulse_q;
  logic [4:0] chan_q;
  logic [1:0] ref_q;
  logic halted_q;
  logic locked;
  logic last_cycle;
  logic complete;
  logic sleep_mode_ok;
  logic sleep_trig;
  logic begin_conv;
  logic restart;

  // ----------------------------------------------------------------
  // converter clock prescaler
  // ----------------------------------------------------------------
  // held in reset while the converter is off, so the first converter
  // edge after enabling comes a full prescale period later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_q <= 4'h0;
    end else if (!link.converter_enable_bit || tick) begin
      presc_q <= 4'h0;
    end else begin
      presc_q <= presc_q + 4'h1;
    end
  end

  assign tick = link.converter_enable_bit &&
                (presc_q == `ASSC_PRESC_DIV - 4'h1);

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  assign last_cycle = (state_q == ASSC_CV_CONV) && (cnt_q == 5'd1);
  assign complete = last_cycle && tick;
  assign begin_conv = (state_q == ASSC_CV_WAIT) && tick;
  assign restart = complete && link.free_running_select_bit && start_q;

  // sleep start only on the halt edge and only for the two quiet states
  assign sleep_mode_ok = (link.sleep_mode == ASSC_SLP_IDLE) ||
                         (link.sleep_mode == ASSC_SLP_NOISE);
  assign sleep_trig = link.cpu_halted && !halted_q && sleep_mode_ok &&
                      link.converter_enable_bit &&
                      !start_q && (state_q == ASSC_CV_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halted_q <= 1'b0;
    end else begin
      halted_q <= link.cpu_halted;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ASSC_CV_IDLE;
    end else if (!link.converter_enable_bit) begin
      state_q <= ASSC_CV_IDLE;
    end else begin
      case (state_q)
        ASSC_CV_IDLE: begin
          if (start_q) begin
            state_q <= ASSC_CV_WAIT;
          end
        end
        ASSC_CV_WAIT: begin
          if (tick) begin
            state_q <= ASSC_CV_CONV;
          end
        end
        ASSC_CV_CONV: begin
          if (complete && !restart) begin
            state_q <= ASSC_CV_IDLE;
          end
        end
        default: state_q <= ASSC_CV_IDLE;
      endcase
    end
  end

  // remaining converter cycles of the running conversion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 5'd0;
    end else if (begin_conv) begin
      cnt_q <= first_q ? `ASSC_FIRST_CYCLES : `ASSC_NORMAL_CYCLES;
    end else if (restart) begin
      cnt_q <= `ASSC_NORMAL_CYCLES;
    end else if (tick && state_q == ASSC_CV_CONV) begin
      cnt_q <= cnt_q - 5'd1;
    end
  end

  // extended first conversion after every enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_q <= 1'b1;
    end else if (!link.converter_enable_bit) begin
      first_q <= 1'b1;
    end else if (begin_conv) begin
      first_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // start bit and done flag
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_q <= 1'b0;
    end else if (!link.converter_enable_bit) begin
      start_q <= 1'b0;
    end else if (link.start_wr || sleep_trig) begin
      start_q <= 1'b1;
    end else if (complete && !link.free_running_select_bit) begin
      start_q <= 1'b0;
    end
  end

  // completion wins over a clear in the same cycle; the request is
  // raised even if the processor already woke on something else
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (complete) begin
      done_q <= 1'b1;
    end else if (link.done_clr) begin
      done_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sample and result
  // ----------------------------------------------------------------
  // the hold point sits eleven cycles before the end for both lengths
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_q <= 10'h000;
      sample_pulse_q <= 1'b0;
    end else begin
      sample_pulse_q <= tick && state_q == ASSC_CV_CONV &&
                        cnt_q == `ASSC_SAMPLE_LEFT;
      if (tick && state_q == ASSC_CV_CONV &&
          cnt_q == `ASSC_SAMPLE_LEFT) begin
        sample_q <= sat_code(ain_level);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= 10'h000;
    end else if (complete) begin
      result_q <= sample_q;
    end
  end

  // ----------------------------------------------------------------
  // channel and reference selection
  // ----------------------------------------------------------------
  // a free-running restart locks whatever was live at completion, so
  // a write after completion only reaches the conversion after that
  assign locked = (state_q == ASSC_CV_CONV) && !last_cycle;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_q <= 5'h00;
      ref_q <= 2'h0;
    end else if (link.converter_enable_bit && !locked) begin
      chan_q <= link.chan_sel;
      ref_q <= link.reference_select_field;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.conversion_start_bit = start_q;
  assign link.conversion_done_flag = done_q;
  assign link.busy = (state_q != ASSC_CV_IDLE);
  assign link.result = result_q;
  assign chan_o = chan_q;
  assign ref_sel_o = ref_q;
  assign supply_sw_o = ref_drive(ref_q) == 2'b10;
  assign bandgap_on_o = ref_drive(ref_q) == 2'b01;
  assign sample_o = sample_pulse_q;
  assign converting_o = (state_q == ASSC_CV_CONV);

endmodule

// ===== design/assc_host.sv
// processor-side controller: register file on AHB-Lite and sleep control
`include "assc_defines.svh"

module assc_host
  import assc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_irq,
  output logic adc_irq,
  output logic wake,
  output logic asleep,
  assc_link_if.host link
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic en_q, free_q, ie_q;
  logic [4:0] chan_q;
  logic [1:0] ref_q;
  logic start_wr_q, done_clr_q, wake_q;
  logic [2:0] mode_q;
  assc_cpu_e cpu_q;
  logic wr_q;
  logic [3:0] addr_q;
  logic [31:0] rdata_q;
  logic [2:0] irq_sync_q;
  logic irq_pin_q;
  logic addr_ok;
  logic any_irq;
  logic [31:0] rd_val;

  // ----------------------------------------------------------------
  // bus slave: zero wait, address captured, data phase next cycle
  // ----------------------------------------------------------------
  assign addr_ok = hsel && htrans[1] && hready;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (haddr[3:0])
      `ASSC_OFS_CTRL: begin
        rd_val[`ASSC_CTRL_EN] = en_q;
        rd_val[`ASSC_CTRL_START] = link.conversion_start_bit;
        rd_val[`ASSC_CTRL_FREE] = free_q;
        rd_val[`ASSC_CTRL_IE] = ie_q;
        rd_val[`ASSC_CTRL_CHAN_HI:`ASSC_CTRL_CHAN_LO] = chan_q;
        rd_val[`ASSC_CTRL_REF_HI:`ASSC_CTRL_REF_LO] = ref_q;
      end
      `ASSC_OFS_STAT: begin
        rd_val[`ASSC_STAT_DONE] = link.conversion_done_flag;
        rd_val[`ASSC_STAT_BUSY] = link.busy;
        rd_val[`ASSC_STAT_ASLEEP] = (cpu_q != ASSC_CPU_RUN);
        rd_val[`ASSC_STAT_RES_HI:`ASSC_STAT_RES_LO] = link.result;
      end
      `ASSC_OFS_SLEEP: begin
        rd_val[`ASSC_SLEEP_MODE_HI:`ASSC_SLEEP_MODE_LO] = mode_q;
      end
      default: rd_val = 32'h0000_0000;
    endcase
    if (haddr[31:4] != 28'h0) begin
      rd_val = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 4'h0;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= addr_ok && hwrite && (haddr[31:4] == 28'h0);
      if (addr_ok) begin
        addr_q <= haddr[3:0];
        rdata_q <= rd_val;
      end
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // selections pass straight on; ordering them against the start bit
  // and keeping the reference choice legal is software's job
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 1'b0;
      free_q <= 1'b0;
      ie_q <= 1'b0;
      chan_q <= 5'h00;
      ref_q <= 2'h0;
    end else if (wr_q && addr_q == `ASSC_OFS_CTRL) begin
      en_q <= hwdata[`ASSC_CTRL_EN];
      free_q <= hwdata[`ASSC_CTRL_FREE];
      ie_q <= hwdata[`ASSC_CTRL_IE];
      chan_q <= hwdata[`ASSC_CTRL_CHAN_HI:`ASSC_CTRL_CHAN_LO];
      ref_q <= hwdata[`ASSC_CTRL_REF_HI:`ASSC_CTRL_REF_LO];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_wr_q <= 1'b0;
      done_clr_q <= 1'b0;
    end else begin
      start_wr_q <= wr_q && addr_q == `ASSC_OFS_CTRL &&
                    hwdata[`ASSC_CTRL_START] && hwdata[`ASSC_CTRL_EN];
      done_clr_q <= wr_q && addr_q == `ASSC_OFS_STAT &&
                    hwdata[`ASSC_STAT_DONE];
    end
  end

  // ----------------------------------------------------------------
  // sleep controller
  // ----------------------------------------------------------------
  // pin passes three stages; a level counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_sync_q <= 3'b000;
      irq_pin_q <= 1'b0;
    end else begin
      irq_sync_q <= {irq_sync_q[1:0], ext_irq};
      if (irq_sync_q[1] == irq_sync_q[2]) begin
        irq_pin_q <= irq_sync_q[2];
      end
    end
  end

  assign adc_irq = link.conversion_done_flag && ie_q;
  assign any_irq = adc_irq || irq_pin_q;

  // the converter enable is never touched here, whatever the sleep state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_q <= ASSC_CPU_RUN;
      mode_q <= 3'h0;
      wake_q <= 1'b0;
    end else begin
      wake_q <= 1'b0;
      case (cpu_q)
        ASSC_CPU_RUN: begin
          if (wr_q && addr_q == `ASSC_OFS_SLEEP) begin
            mode_q <= hwdata[`ASSC_SLEEP_MODE_HI:`ASSC_SLEEP_MODE_LO];
            cpu_q <= ASSC_CPU_HALTING;
          end
        end
        ASSC_CPU_HALTING: begin
          cpu_q <= ASSC_CPU_SLEEP;
        end
        ASSC_CPU_SLEEP: begin
          if (any_irq) begin
            cpu_q <= ASSC_CPU_RUN;
            wake_q <= 1'b1;
          end
        end
        default: cpu_q <= ASSC_CPU_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link outputs
  // ----------------------------------------------------------------
  assign link.converter_enable_bit = en_q;
  assign link.start_wr = start_wr_q;
  assign link.free_running_select_bit = free_q;
  assign link.chan_sel = chan_q;
  assign link.reference_select_field = ref_q;
  assign link.done_clr = done_clr_q;
  assign link.cpu_halted = (cpu_q == ASSC_CPU_SLEEP);
  assign link.sleep_mode = mode_q;
  assign wake = wake_q;
  assign asleep = (cpu_q != ASSC_CPU_RUN);

endmodule

// ===== tb/assc_link_chk.sv
// checker of the link between the controller and the converter control
module assc_link_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic converter_enable_bit,
  input wire logic start_wr,
  input wire logic free_running_select_bit,
  input wire logic done_clr,
  input wire logic cpu_halted,
  input wire logic [2:0] sleep_mode,
  input wire logic conversion_start_bit,
  input wire logic conversion_done_flag,
  input wire logic busy
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic [9:0] run_q;
  wire en = converter_enable_bit;
  wire st = conversion_start_bit;
  wire dn = conversion_done_flag;
  wire fr = free_running_select_bit;
  wire lo_mode = sleep_mode[2:1] == 2'h0;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // coarse on purpose: prescaler phase gives up to one tick of slack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 10'h0;
    end else begin
      run_q <= st ? run_q + 10'h1 : 10'h0;
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_start_set; start_wr && en |=> st; endproperty
  a_start_set:
    assert property (p_start_set) else $error("start bit not set");
  property p_start_hold; $fell(st) && $past(en) && en |-> dn; endproperty
  a_start_hold:
    assert property (p_start_hold) else $error("start bit dropped early");
  property p_single_clr; $rose(dn) && !fr |-> !st; endproperty
  a_single_clr:
    assert property (p_single_clr) else $error("start bit kept");
  property p_free_next; $rose(dn) && fr && en |-> st; endproperty
  a_free_next:
    assert property (p_free_next) else $error("free run stopped");
  property p_conv_len;
    $fell(st) && $past(en) && en |-> run_q inside {[45:60], [93:110]};
  endproperty
  a_conv_len:
    assert property (p_conv_len) else $error("wrong conversion length");
  property p_sleep_go;
    $rose(cpu_halted) && lo_mode && en && !st && !busy |-> ##[1:2] st;
  endproperty
  a_sleep_go:
    assert property (p_sleep_go) else $error("no sleep conversion");
  property p_sleep_no;
    $rose(cpu_halted) && !st && !(lo_mode && en) |=> !st [*2];
  endproperty
  a_sleep_no:
    assert property (p_sleep_no) else $error("unwanted sleep conversion");
  property p_keep_en; cpu_halted && en |=> en; endproperty
  a_keep_en:
    assert property (p_keep_en) else $error("enable lost in sleep");
  property p_done_keep; dn && !done_clr |=> dn; endproperty
  a_done_keep:
    assert property (p_done_keep) else $error("done flag lost");
  c_sleep: cover property ($rose(cpu_halted) ##[1:2] st);
  c_free: cover property ($rose(dn) && fr);
  c_wake_mid: cover property (cpu_halted ##1 !cpu_halted && st);
endmodule

// ===== tb/adc_select_and_sleep_conversion_tb.sv
// testbench of the converter control joined to its controller
module adc_select_and_sleep_conversion_tb import assc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic ext_irq = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [10:0] ain_level = 11'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, adc_irq, asleep, supply_sw_o, bandgap_on_o;
  logic hresp, wake, sample_o, converting_o;
  logic [4:0] chan_o;
  logic [1:0] ref_sel_o;
  logic [3:0] rf;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int wakes = 0;
  int samples = 0;
  int n;
  assc_link_if link ();
  always #10 hclk = ~hclk;

  assc_host assc_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_irq(ext_irq),
    .adc_irq(adc_irq), .wake(wake), .asleep(asleep), .link(link));
  assc_device assc_device_inst (.hclk(hclk), .hresetn(hresetn),
    .link(link), .ain_level(ain_level), .chan_o(chan_o),
    .ref_sel_o(ref_sel_o), .supply_sw_o(supply_sw_o),
    .bandgap_on_o(bandgap_on_o), .sample_o(sample_o),
    .converting_o(converting_o));
  assc_link_chk assc_link_chk_inst (.hclk(hclk), .hresetn(hresetn),
    .converter_enable_bit(link.converter_enable_bit),
    .start_wr(link.start_wr),
    .free_running_select_bit(link.free_running_select_bit),
    .done_clr(link.done_clr), .cpu_halted(link.cpu_halted),
    .sleep_mode(link.sleep_mode),
    .conversion_start_bit(link.conversion_start_bit),
    .conversion_done_flag(link.conversion_done_flag), .busy(link.busy));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // entered just after a rising edge; read data taken at the final edge
  task automatic bus(input logic w, input logic [31:0] a, d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
    check(32'(hresp), 32'h0);
  endtask

  function automatic logic [31:0] cw(input logic [4:0] ch,
                                     input logic [1:0] rs,
                                     input logic [3:0] b);
    return {16'h0, rs, 1'b0, ch, 4'h0, b};
  endfunction

  // polls on the falling edge so the flag has settled
  task automatic wait_done();
    for (n = 0; n < 600 && link.conversion_done_flag !== 1'b1; n++) begin
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  // one wake pulse per leave of sleep, one hold pulse per conversion
  always @(posedge hclk) begin
    if (wake === 1'b1) begin
      wakes++;
    end
    if (sample_o === 1'b1) begin
      samples++;
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(32'h0, 32'h0);
    rd_chk(32'h4, 32'h0);
    rd_chk(32'h10, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 32'h0, cw(5'h0, 2'(i), 4'h1));
      repeat (2) @(posedge hclk);
      #1;
      rf = {ref_sel_o, supply_sw_o, bandgap_on_o};
      check(32'(rf), 32'({2'(i), i == 1, i == 3}));
    end
    // first conversion after enabling, input above the reference
    bus(1'b1, 32'h0, 32'h0);
    ain_level <= 11'h400;
    bus(1'b1, 32'h0, cw(5'h3, 2'h3, 4'h3));
    wait_done();
    check(32'(n > 90 && n < 112), 32'h1);
    rd_chk(32'h4, 32'h03ff0001);
    rd_chk(32'h0, cw(5'h3, 2'h3, 4'h1));
    check(32'(chan_o), 32'h3);
    // normal conversion, channel rewritten while it runs
    bus(1'b1, 32'h4, 32'h1);
    ain_level <= 11'h155;
    bus(1'b1, 32'h0, cw(5'h3, 2'h3, 4'h3));
    // the channel moves only once the conversion has surely begun
    repeat (6) @(posedge hclk);
    bus(1'b1, 32'h0, cw(5'h5, 2'h3, 4'h1));
    repeat (2) @(posedge hclk);
    #1;
    check(32'(converting_o), 32'h1);
    check(32'(chan_o), 32'h3);
    wait_done();
    check(32'(n > 38 && n < 62), 32'h1);
    rd_chk(32'h4, 32'h01550001);
    check(32'(chan_o), 32'h5);
    // free running: change after a completion skips one conversion
    bus(1'b1, 32'h4, 32'h1);
    bus(1'b1, 32'h0, cw(5'h1, 2'h1, 4'h7));
    wait_done();
    bus(1'b1, 32'h0, cw(5'h2, 2'h1, 4'h5));
    bus(1'b1, 32'h4, 32'h1);
    #1;
    check(32'(chan_o), 32'h1);
    repeat (3) @(posedge hclk);
    wait_done();
    check(32'(link.conversion_start_bit), 32'h1);
    check(32'(chan_o), 32'h2);
    bus(1'b1, 32'h0, 32'h0);
    // sleep-started conversions in idle and noise-reduction states
    bus(1'b1, 32'h0, cw(5'h0, 2'h1, 4'h9));
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, 32'h4, 32'h1);
      repeat (3) @(posedge hclk);
      bus(1'b1, 32'h8, 32'(m));
      wait_done();
      repeat (6) @(posedge hclk);
      #1;
      check(32'({adc_irq, asleep}), 32'h2);
      rd_chk(32'h4, 32'h01550001);
    end
    // other sleep state: nothing starts, enable stays, pin wakes it
    bus(1'b1, 32'h4, 32'h1);
    bus(1'b1, 32'h8, 32'h2);
    repeat (150) @(posedge hclk);
    #1;
    check(32'(link.conversion_done_flag), 32'h0);
    check(32'(link.converter_enable_bit), 32'h1);
    ext_irq <= 1'b1;
    repeat (6) @(posedge hclk);
    ext_irq <= 1'b0;
    // let the synchronised pin fall, or it wakes the next sleep at once
    repeat (6) @(posedge hclk);
    // pin wakes before the sleep conversion has finished
    bus(1'b1, 32'h8, 32'h1);
    repeat (10) @(posedge hclk);
    ext_irq <= 1'b1;
    repeat (6) @(posedge hclk);
    ext_irq <= 1'b0;
    #1;
    check(32'({asleep, link.conversion_done_flag}), 32'h0);
    wait_done();
    repeat (2) @(posedge hclk);
    #1;
    check(32'({adc_irq, asleep}), 32'h2);
    check(32'(wakes), 32'h4);
    check(32'(samples), 32'h7);
    finish_test();
  end
endmodule
